// ---- core/serial_params.sv ----
`timescale 1ns/100ps
`include "serial_params_regs.svh"

module serial_params #(
    parameter int          EVENT_DEPTH   = 8,
    parameter int unsigned STORE_CYCLES  = `SP_STORE_CYCLES,
    parameter int unsigned MS_CYCLES     = `SP_MS_CYCLES,
    parameter int unsigned TEST_MS       = `SP_DISPLAY_TEST_MS
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        ev_valid,
    input  wire logic [5:0]  ev_chan,
    input  wire logic [9:0]  ev_code,
    input  wire logic        auto_reset_seen,
    input  wire logic [7:0]  fault_code,
    input  wire logic        buttons_held,
    input  wire logic        nv_ack,
    output logic             supervision_out,
    output logic             display_test_active,
    output logic             display_on,
    output logic             nv_write,
    output logic      [15:0] nv_data,
    output logic      [15:0] param_word,
    output logic             irq
);

    localparam int PW = $clog2(EVENT_DEPTH);

    typedef struct packed {
        logic [1:0]                    boot_cnt;
        logic                          strap_taken;
        serial_params_pkg::nv_state_type nv_state;
        logic [31:0]                   nv_cnt;
        logic                          sup;
        logic                          test;
        logic [31:0]                   test_ms;
        logic [31:0]                   ms_cnt;
        logic [15:0]                   time_ms;
        logic                          stat_reset;
        logic                          stat_ovf;
        logic [PW:0]                   wp;
        logic [PW:0]                   rp;
        serial_params_pkg::event_type  last_ev;
        logic                          last_valid;
        logic [15:0]                   param;
        logic                          param_dirty;
        logic [15:0]                   saved;
        logic [`SP_IRQ_WIDTH-1:0]      irq_stat;
        logic [`SP_IRQ_WIDTH-1:0]      irq_mask;
        logic                          disp_on;
        logic [31:0]                   rdata;
    } state_type;

    state_type q, d;
    serial_params_pkg::event_type mem [EVENT_DEPTH];
    logic                         mem_we;
    logic [PW-1:0]                mem_wa;
    serial_params_pkg::event_type mem_wd;

    logic [PW:0]             fill;
    logic                    ev_empty;
    logic                    ev_full;
    logic [`SP_IRQ_WIDTH-1:0] ev_set;
    logic                    rd_ok;
    logic                    wr_ok;
    logic                    btn_held_s;
    logic                    nv_ack_s;

    // Buttons and memory ready come from outside the clock domain
    level_sync btn_sync_i (
        .clk    (clk),
        .arst_n (arst_n),
        .din    (buttons_held),
        .dout   (btn_held_s)
    );

    level_sync ack_sync_i (
        .clk    (clk),
        .arst_n (arst_n),
        .din    (nv_ack),
        .dout   (nv_ack_s)
    );

    assign fill     = q.wp - q.rp;
    assign ev_empty = (fill == '0);
    assign ev_full  = (fill == (PW+1)'(EVENT_DEPTH));

    // Write-only and read-only addresses
    always_comb begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
        case (addr)
            `SP_SUPERVISION_OUTPUT_CTRL,
            `SP_DISPLAY_TEST_TRIGGER,
            `SP_STORE_TO_NONVOLATILE: rd_ok = 1'b0;
            `SP_INTERNAL_FAULT_VALUE,
            `SP_EVENT_READ,
            `SP_EVENT_REREAD,
            `SP_CTRL_STATUS: wr_ok = 1'b0;
            `SP_MODULE_STATUS,
            `SP_TIME_MS,
            `SP_PARAM_WORD,
            `SP_IRQ_STATUS,
            `SP_IRQ_MASK,
            `SP_EVENT_PUSH: begin
            end
            default: begin
                rd_ok = 1'b0;
                wr_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        d        = q;
        mem_we   = 1'b0;
        mem_wa   = q.wp[PW-1:0];
        mem_wd   = '{time_ms: q.time_ms, chan: ev_chan, code: ev_code};
        ev_set   = '0;
        d.rdata  = 32'h0;

        // Millisecond time base, wraps after 59.999 s
        if (q.ms_cnt >= MS_CYCLES - 32'd1) begin
            d.ms_cnt = 32'h0;
            d.time_ms = (q.time_ms >= `SP_TIME_MAX_MS) ? 16'h0 : q.time_ms + 16'h1;
            if (q.test) begin
                if (q.test_ms >= TEST_MS - 32'd1) begin
                    d.test    = 1'b0;
                    d.test_ms = 32'h0;
                end else begin
                    d.test_ms = q.test_ms + 32'h1;
                end
            end
        end else begin
            d.ms_cnt = q.ms_cnt + 32'h1;
        end

        if (auto_reset_seen) begin
            d.stat_reset = 1'b1;
        end

        // Power-up default load and nonvolatile store sequencer
        case (q.nv_state)
            serial_params_pkg::ST_DEFAULT: begin
                d.param       = `SP_PARAM_DEFAULT;
                d.param_dirty = 1'b1;
                d.disp_on     = 1'b1;
                d.nv_state    = serial_params_pkg::ST_IDLE;
            end
            serial_params_pkg::ST_STORE: begin
                if (q.nv_cnt >= STORE_CYCLES - 32'd1 && nv_ack_s) begin
                    d.saved    = q.param;
                    d.nv_state = serial_params_pkg::ST_IDLE;
                    d.nv_cnt   = 32'h0;
                    ev_set[`SP_IRQ_STORE_DONE_BIT] = 1'b1;
                end else if (q.nv_cnt < STORE_CYCLES - 32'd1) begin
                    d.nv_cnt = q.nv_cnt + 32'h1;
                end
            end
            serial_params_pkg::ST_IDLE: begin
                // The strap is read only once the button level has settled
                if (!q.strap_taken && q.boot_cnt != 2'd2) begin
                    d.boot_cnt = q.boot_cnt + 2'd1;
                end else if (!q.strap_taken) begin
                    d.strap_taken = 1'b1;
                    if (btn_held_s) begin
                        d.nv_state = serial_params_pkg::ST_DEFAULT;
                    end else begin
                        d.param   = q.saved;
                        d.disp_on = 1'b1;
                    end
                end
            end
            default: d.nv_state = serial_params_pkg::ST_IDLE;
        endcase

        // Event capture from the module's own functions
        if (ev_valid) begin
            if (ev_full) begin
                d.stat_ovf = 1'b1;
                ev_set[`SP_IRQ_OVERFLOW_BIT] = 1'b1;
            end else begin
                mem_we = 1'b1;
                d.wp   = q.wp + (PW+1)'(1);
                ev_set[`SP_IRQ_EVENT_BIT] = 1'b1;
            end
        end

        if (rd) begin
            if (!rd_ok) begin
                ev_set[`SP_IRQ_ACCESS_ERR_BIT] = 1'b1;
            end else begin
                case (addr)
                    `SP_INTERNAL_FAULT_VALUE: d.rdata = {24'h0, fault_code};
                    `SP_EVENT_READ: begin
                        if (!ev_empty) begin
                            d.last_ev    = mem[q.rp[PW-1:0]];
                            d.last_valid = 1'b1;
                            d.rp         = q.rp + (PW+1)'(1);
                            d.rdata      = mem[q.rp[PW-1:0]];
                        end
                    end
                    `SP_EVENT_REREAD: d.rdata = q.last_valid ? q.last_ev : 32'h0;
                    `SP_MODULE_STATUS: d.rdata = {30'h0, q.stat_ovf, q.stat_reset};
                    `SP_TIME_MS: d.rdata = {16'h0, q.time_ms};
                    `SP_PARAM_WORD: d.rdata = {16'h0, q.param};
                    `SP_IRQ_STATUS: d.rdata = {28'h0, q.irq_stat};
                    `SP_IRQ_MASK: d.rdata = {28'h0, q.irq_mask};
                    `SP_CTRL_STATUS: d.rdata = {26'h0, q.param_dirty, q.disp_on, q.nv_state,
                                                q.test, q.sup};
                    default: d.rdata = 32'h0;
                endcase
            end
        end

        if (wr) begin
            if (!wr_ok) begin
                ev_set[`SP_IRQ_ACCESS_ERR_BIT] = 1'b1;
            end else begin
                case (addr)
                    `SP_SUPERVISION_OUTPUT_CTRL: begin
                        if (wdata == 32'h1) d.sup = 1'b1;
                        else if (wdata == 32'h0) d.sup = 1'b0;
                    end
                    `SP_DISPLAY_TEST_TRIGGER: begin
                        if (wdata == 32'h1) begin
                            d.test    = 1'b1;
                            d.test_ms = 32'h0;
                        end
                    end
                    `SP_MODULE_STATUS: begin
                        if (wdata == 32'h0) begin
                            d.stat_reset = auto_reset_seen;
                            d.stat_ovf   = ev_valid && ev_full;
                        end
                    end
                    `SP_TIME_MS: begin
                        if (wdata[15:0] <= `SP_TIME_MAX_MS) begin
                            d.time_ms = wdata[15:0];
                            d.ms_cnt  = 32'h0;
                        end
                    end
                    `SP_STORE_TO_NONVOLATILE: begin
                        if (wdata == 32'h1 && q.nv_state == serial_params_pkg::ST_IDLE
                            && q.strap_taken) begin
                            d.nv_state    = serial_params_pkg::ST_STORE;
                            d.nv_cnt      = 32'h0;
                            d.param_dirty = 1'b0;
                        end
                    end
                    `SP_PARAM_WORD: begin
                        d.param       = wdata[15:0];
                        d.param_dirty = 1'b1;
                    end
                    `SP_IRQ_MASK: d.irq_mask = wdata[`SP_IRQ_WIDTH-1:0];
                    `SP_EVENT_PUSH: begin
                        if (ev_full) begin
                            d.stat_ovf = 1'b1;
                            ev_set[`SP_IRQ_OVERFLOW_BIT] = 1'b1;
                        end else if (!ev_valid) begin
                            mem_we = 1'b1;
                            mem_wd = '{time_ms: q.time_ms, chan: wdata[15:10],
                                       code: wdata[9:0]};
                            d.wp   = q.wp + (PW+1)'(1);
                            ev_set[`SP_IRQ_EVENT_BIT] = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Sticky interrupt bits: set wins over write-one-to-clear
        if (wr && wr_ok && addr == `SP_IRQ_STATUS) begin
            d.irq_stat = q.irq_stat & ~wdata[`SP_IRQ_WIDTH-1:0];
        end
        d.irq_stat = d.irq_stat | ev_set;
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.saved <= `SP_PARAM_DEFAULT;
        end else begin
            q <= d;
        end
    end

    assign rdata               = q.rdata;
    assign supervision_out     = q.sup;
    assign display_test_active = q.test;
    assign display_on          = q.disp_on;
    assign nv_write            = (q.nv_state == serial_params_pkg::ST_STORE);
    assign nv_data             = q.param;
    assign param_word          = q.param;
    assign irq                 = |(q.irq_stat & q.irq_mask);

endmodule

// Two-flop synchroniser for a level from outside the clock domain
module level_sync (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic din,
    output logic      dout
);

    typedef struct packed {
        logic meta;
        logic sync;
    } sync_state_type;

    sync_state_type q, d;

    always_comb begin
        d.meta = din;
        d.sync = q.meta;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.sync;

endmodule

// ---- core/serial_params_regs.svh ----
`ifndef SERIAL_PARAMS_REGS_SVH
`define SERIAL_PARAMS_REGS_SVH

// Register offsets (byte addresses, one word each)
`define SP_SUPERVISION_OUTPUT_CTRL  8'h00
`define SP_DISPLAY_TEST_TRIGGER     8'h04
`define SP_INTERNAL_FAULT_VALUE     8'h08
`define SP_EVENT_READ               8'h0c
`define SP_EVENT_REREAD             8'h10
`define SP_MODULE_STATUS            8'h14
`define SP_TIME_MS                  8'h18
`define SP_STORE_TO_NONVOLATILE     8'h1c
`define SP_PARAM_WORD               8'h20
`define SP_IRQ_STATUS               8'h24
`define SP_IRQ_MASK                 8'h28
`define SP_CTRL_STATUS              8'h2c
`define SP_EVENT_PUSH               8'h30

// Module status codes
`define SP_STAT_AUTO_RESET_BIT      0
`define SP_STAT_OVERFLOW_BIT        1

// Interrupt status bit positions
`define SP_IRQ_EVENT_BIT            0
`define SP_IRQ_OVERFLOW_BIT         1
`define SP_IRQ_STORE_DONE_BIT       2
`define SP_IRQ_ACCESS_ERR_BIT       3
`define SP_IRQ_WIDTH                4

// Time value
`define SP_TIME_MAX_MS              16'd59999
`define SP_MS_CYCLES                32'd20000
`define SP_CLK_HZ                   32'd20000000

// Nonvolatile store time in seconds, and the cycles it takes
`define SP_STORE_TIME_S             32'd10
`define SP_STORE_CYCLES             (`SP_STORE_TIME_S * `SP_CLK_HZ)

// Display test length in milliseconds
`define SP_DISPLAY_TEST_MS          32'd2000

// Factory default of the persistent parameter word
`define SP_PARAM_DEFAULT            16'h0143

`endif

// ---- core/serial_params_pkg.sv ----
package serial_params_pkg;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_DEFAULT = 2'b01,
        ST_STORE   = 2'b10
    } nv_state_type;

    typedef struct packed {
        logic [15:0] time_ms;
        logic [5:0]  chan;
        logic [9:0]  code;
    } event_type;

endpackage

// ---- test/nv_model.sv ----
`timescale 1ns/100ps

module nv_model #(
    parameter int BUSY = 5
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic nv_write,
    output logic      nv_ack
);
    int cnt;
    // Ready drops while a save runs, then comes back after BUSY cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt    <= 0;
            nv_ack <= 1'b1;
        end else if (nv_write && cnt < BUSY) begin
            cnt    <= cnt + 1;
            nv_ack <= 1'b0;
        end else begin
            if (!nv_write) cnt <= 0;
            nv_ack <= 1'b1;
        end
    end
endmodule

// ---- test/serial_params_monitor.sv ----
`timescale 1ns/100ps

module serial_params_monitor #(
    parameter int unsigned STORE_CYCLES = 20
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic [7:0]  fault_code,
    input wire logic        supervision_out,
    input wire logic        display_test_active,
    input wire logic        nv_write
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    int unsigned wr_cnt_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) wr_cnt_q <= 0;
        else wr_cnt_q <= nv_write ? wr_cnt_q + 1 : 0;
    end
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside read answer");
    sup_set_a: assert property (wr && addr == 8'h00 && wdata == 32'h1 |=> supervision_out)
        else $error("supervision output not set");
    sup_clr_a: assert property (wr && addr == 8'h00 && wdata == 32'h0 |=> !supervision_out)
        else $error("supervision output not cleared");
    disp_start_a: assert property (wr && addr == 8'h04 && wdata == 32'h1 |=> display_test_active)
        else $error("display test not started");
    status_code_a: assert property (rd && addr == 8'h14 |=> rdata[31:2] == 30'h0)
        else $error("status read out of range");
    fault_read_a: assert property (rd && addr == 8'h08 |=> rdata == {24'h0, $past(fault_code)})
        else $error("fault code read wrong");
    wo_read_a: assert property (rd && (addr == 8'h04 || addr == 8'h1c) |=> rdata == 32'h0)
        else $error("write-only read not refused");
    time_range_a: assert property (rd && addr == 8'h18 |=> rdata <= 32'd59999)
        else $error("time value above limit");
    store_len_a: assert property ($fell(nv_write) |-> wr_cnt_q >= STORE_CYCLES - 1)
        else $error("store finished too early");
    ev_read_c: cover property (rd && addr == 8'h0c);
    reread_c: cover property (rd && addr == 8'h10);
    store_c: cover property ($fell(nv_write));
endmodule

bind serial_params serial_params_monitor #(.STORE_CYCLES(STORE_CYCLES)) mon (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fault_code(fault_code), .supervision_out(supervision_out),
    .display_test_active(display_test_active), .nv_write(nv_write));

// ---- test/serial_params_tb.sv ----
`timescale 1ns/100ps

module serial_params_tb;
    logic        clk, arst_n, wr, rd, ev_valid, auto_reset_seen, buttons_held, nv_ack;
    logic [7:0]  addr, fault_code;
    logic [31:0] wdata, rdata;
    logic [5:0]  ev_chan;
    logic [9:0]  ev_code;
    logic        supervision_out, display_test_active, display_on, nv_write, irq;
    logic [15:0] nv_data, param_word;
    int          fail_count, samples_checked, cyc;

    serial_params #(.STORE_CYCLES(20), .MS_CYCLES(4), .TEST_MS(3)) dut (
        .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ev_valid(ev_valid), .ev_chan(ev_chan), .ev_code(ev_code),
        .auto_reset_seen(auto_reset_seen), .fault_code(fault_code),
        .buttons_held(buttons_held), .nv_ack(nv_ack), .supervision_out(supervision_out),
        .display_test_active(display_test_active), .display_on(display_on),
        .nv_write(nv_write), .nv_data(nv_data), .param_word(param_word), .irq(irq));
    nv_model #(.BUSY(30)) nv (.clk(clk), .arst_n(arst_n), .nv_write(nv_write), .nv_ack(nv_ack));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(logic [7:0] a, logic [31:0] e, logic [31:0] m);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("read", e, rdata & m);
    endtask

    task automatic do_reset(logic held);
        arst_n = 1'b0; buttons_held = held;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk("defaults", {15'h0, display_on, param_word}, 32'h0001_0143);
        rd_chk(8'h2c, held ? 32'h30 : 32'h10, 32'h30);
        $display("test reset done");
    endtask

    task automatic t_sup_disp;
        wr_reg(8'h00, 32'h1); chk("sup", 32'h1, {31'h0, supervision_out});
        wr_reg(8'h00, 32'h0); chk("sup", 32'h0, {31'h0, supervision_out});
        wr_reg(8'h04, 32'h1); chk("disp", 32'h1, {31'h0, display_test_active});
        rd_chk(8'h00, 32'h0, 32'hffff_ffff);
        wr_reg(8'h28, 32'h8);
        #1 chk("irq", 32'h1, {31'h0, irq});
        wr_reg(8'h24, 32'hf);
        rd_chk(8'h24, 32'h0, 32'h8);
        fault_code <= 8'h5a;
        wr_reg(8'h08, 32'h11); rd_chk(8'h08, 32'h5a, 32'hffff_ffff);
        rd_chk(8'h24, 32'h8, 32'h8);
        chk("disp_end", 32'h0, {31'h0, display_test_active});
        $display("test sup_disp done");
    endtask

    task automatic t_events;
        @(posedge clk) auto_reset_seen <= 1'b1;
        @(posedge clk) auto_reset_seen <= 1'b0;
        rd_chk(8'h14, 32'h1, 32'hffff_ffff);
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            ev_valid <= 1'b1; ev_chan <= 6'(i + 1); ev_code <= 10'h100 + 10'(i);
        end
        @(posedge clk) ev_valid <= 1'b0;
        rd_chk(8'h14, 32'h3, 32'hffff_ffff);
        wr_reg(8'h14, 32'h0); rd_chk(8'h14, 32'h0, 32'hffff_ffff);
        rd_chk(8'h0c, 32'h0500, 32'hffff);
        rd_chk(8'h10, 32'h0500, 32'hffff);
        rd_chk(8'h10, 32'h0500, 32'hffff);
        for (int i = 1; i < 8; i++) rd_chk(8'h0c, {16'h0, 6'(i + 1), 10'h100 + 10'(i)}, 32'hffff);
        rd_chk(8'h0c, 32'h0, 32'hffff_ffff);
        $display("test events done");
    endtask

    task automatic t_time;
        wr_reg(8'h18, 32'd100); wr_reg(8'h18, 32'd60000);
        rd_chk(8'h18, 32'd100, 32'hffff_ffff);
        wr_reg(8'h18, 32'd59999); rd_chk(8'h18, 32'd59999, 32'hffff_ffff);
        repeat (2) @(posedge clk);
        rd_chk(8'h18, 32'd0, 32'hffff_ffff);
        @(posedge clk);
        rd_chk(8'h18, 32'd1, 32'hffff_ffff);
        $display("test time done");
    endtask

    task automatic t_store;
        int n;
        wr_reg(8'h20, 32'h2bcd); rd_chk(8'h2c, 32'h20, 32'h20);
        wr_reg(8'h1c, 32'h1); chk("nvw", 32'h1, {31'h0, nv_write});
        n = 0;
        while (nv_write === 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        #1 chk("nvdata", 32'h2bcd, {16'h0, nv_data});
        chk("nvw_end", 32'h0, {31'h0, nv_write});
        chk("store_len", 32'h1, {31'h0, (n >= 20)});
        rd_chk(8'h24, 32'h4, 32'h4);
        $display("test store done");
    endtask

    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        {wr, rd, ev_valid, auto_reset_seen} = 4'h0;
        addr = 8'h00; wdata = 32'h0; ev_chan = 6'h00; ev_code = 10'h000; fault_code = 8'h00;
        fail_count = 0; samples_checked = 0; cyc = 0;
        do_reset(1'b1);
        t_sup_disp();
        t_events();
        t_time();
        t_store();
        do_reset(1'b0);
        end_of_test();
    end
endmodule
